// *** dv/sdcd_ctrl_model.sv ***
// Controller model that drives spaced commands onto the decoder pins.
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model
	import sdcd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic req_valid,
	input wire sdcd_pkg::sdcd_pins_t req,
	output logic req_ready,
	output sdcd_pkg::sdcd_pins_t pins
);
	import sdcd_pkg::*;
	logic gap_reg;
	int seed = 32'h2c9e;
	assign req_ready = !gap_reg;
	// ****************
	// Command spacing.
	// ****************
	// One idle cycle after every command meets each spacing of two clocks or less.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gap_reg <= 1'b0;
			pins <= '{cke: 1'b1, cs_n: 1'b1, default: '0};
		end else if (req_valid && req_ready) begin
			pins <= req;
			gap_reg <= 1'b1;
		end else begin
			pins <= {2'h3, 19'($random(seed))};
			gap_reg <= 1'b0;
		end
	end
endmodule : sdcd_ctrl_model
`default_nettype wire

// *** dv/sdcd_top_sva.sv ***
// Assertions on the ports of the command decoder.
`timescale 1ns/1ps
`default_nettype none
module sdcd_top_sva
	import sdcd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire sdcd_pkg::sdcd_pins_t pins,
	input wire logic read_active,
	input wire sdcd_pkg::sdcd_dec_t dec,
	input wire logic cmd_valid,
	input wire logic read_out_enable,
	input wire logic [1:0] drive_strength,
	input wire logic timing_error,
	input wire logic deep_power_down,
	input wire logic self_refresh,
	input wire logic write_mask,
	input wire logic [12:0] refresh_row,
	input wire logic [1:0] refresh_bank
);
	import sdcd_pkg::*;
	wire logic [3:0] k = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
	// ***********
	// Properties.
	// ***********
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	property p_desel;
		pins.cs_n |-> ##2 dec.cmd == SDCD_CMD_NOP;
	endproperty
	a_desel: assert property (p_desel) else $error("deselect decoded");
	property p_valid;
		cmd_valid |-> !$past(pins.cs_n, 2) && dec.cmd != SDCD_CMD_NOP;
	endproperty
	a_valid: assert property (p_valid) else $error("bad command pulse");
	property p_open;
		k == 4'b0011 |-> ##2 dec.cmd == SDCD_CMD_ROW_OPEN && dec.row == $past(pins.addr, 2) && dec.bank == $past(pins.ba, 2);
	endproperty
	a_open: assert property (p_open) else $error("row open decode");
	property p_read;
		k == 4'b0101 |-> ##2 dec.cmd == SDCD_CMD_READ && dec.col == $past(pins.addr[8:0], 2)
			&& dec.auto_pre == $past(pins.addr[10], 2);
	endproperty
	a_read: assert property (p_read) else $error("read decode");
	property p_stop;
		k == 4'b0110 |-> ##2 dec.cmd == ($past(pins.cke, 2) ? SDCD_CMD_BURST_STOP : SDCD_CMD_DEEP_PD);
	endproperty
	a_stop: assert property (p_stop) else $error("stop decode");
	property p_ref;
		k == 4'b0001 |-> ##2 dec.cmd == ($past(pins.cke, 2) ? SDCD_CMD_REFRESH : SDCD_CMD_SELF_REFRESH);
	endproperty
	a_ref: assert property (p_ref) else $error("refresh decode");
	property p_pre;
		k == 4'b0010 |-> ##2 dec.cmd == SDCD_CMD_PRECHARGE && dec.all_banks == $past(pins.addr[10], 2);
	endproperty
	a_pre: assert property (p_pre) else $error("precharge decode");
	property p_ds;
		k == 4'b0000 && pins.ba == 2'h2 |-> ##2 drive_strength == $past(pins.addr[6:5], 2);
	endproperty
	a_ds: assert property (p_ds) else $error("drive strength");
	property p_dqm;
		$past(nrst, 3) |-> read_out_enable == (read_active && !$past(pins.dqm, 3));
	endproperty
	a_dqm: assert property (p_dqm) else $error("output enable");
	property p_err;
		timing_error |=> timing_error;
	endproperty
	a_err: assert property (p_err) else $error("error flag dropped");
	property p_rfc;
		k == 4'b0001 |-> ##2 dec.bank == $past(refresh_bank) && dec.row == $past(refresh_row)
			&& {refresh_bank, refresh_row} == 15'({$past(refresh_bank), $past(refresh_row)} + 15'h1);
	endproperty
	a_rfc: assert property (p_rfc) else $error("refresh counter");
	property p_dpd;
		k == 4'b0110 && !pins.cke |-> ##2 deep_power_down;
	endproperty
	a_dpd: assert property (p_dpd) else $error("deep power-down state");
	property p_sref;
		k == 4'b0001 && !pins.cke |-> ##2 self_refresh;
	endproperty
	a_sref: assert property (p_sref) else $error("self refresh state");
	property p_wmask;
		$past(nrst) |-> write_mask == $past(pins.dqm);
	endproperty
	a_wmask: assert property (p_wmask) else $error("write mask");
	c_open: cover property (k == 4'b0011);
	c_ext: cover property (k == 4'b0000 && pins.ba == 2'h2);
	c_err: cover property (timing_error);
endmodule : sdcd_top_sva
`default_nettype wire

// *** dv/sdcd_top_tb.sv ***
// Testbench of the command decoder with a controller model and a result queue.
`timescale 1ns/1ps
`default_nettype none
module sdcd_top_tb;
	import sdcd_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	logic burst_active = 1'b0;
	logic read_active = 1'b0;
	logic req_ready, cmd_valid, timing_error, rd_oe;
	sdcd_pins_t req = '0;
	sdcd_pins_t pins;
	sdcd_dec_t dec, e;
	sdcd_dec_t q[$];
	logic [3:0] bank_open;
	logic [1:0] ds;
	logic [2:0] cl;
	logic [12:0] r, mw, emw;
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 32'h2c9e;
	int cyc = 0;
	always #25 clk_sys = ~clk_sys;
	sdcd_ctrl_model ctl_u (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.pins(pins));
	sdcd_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .burst_active(burst_active), .read_active(read_active),
		.dec(dec), .cmd_valid(cmd_valid), .bank_open(bank_open), .refresh_row(), .refresh_bank(), .deep_power_down(),
		.self_refresh(), .write_mask(), .read_out_enable(rd_oe), .drive_strength(ds), .read_latency(cl),
		.mode_word(mw), .ext_mode_word(emw), .timing_error(timing_error));
	// ******************
	// Checks and drives.
	// ******************
	task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cmd(input logic [3:0] k, input logic c, input logic [1:0] ba, input logic [12:0] a, input sdcd_cmd_t ec);
		req <= '{cke: c, cs_n: k[3], ras_n: k[2], cas_n: k[1], we_n: k[0], dqm: 1'($random(seed)), ba: ba, addr: a};
		req_valid <= 1'b1;
		if (ec != SDCD_CMD_NOP) q.push_back('{cmd: ec, bank: ba, row: a, col: a[8:0], auto_pre: a[10], all_banks: a[10]});
		do @(posedge clk_sys); while (req_ready !== 1'b1);
	endtask : cmd
	task automatic summarize();
		$display("TB: checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		read_active <= 1'($random(seed));
		if (nrst && cmd_valid === 1'b1) begin
			e = q.pop_front();
			chk("cmd", 13'(dec.cmd), 13'(e.cmd));
			if (e.cmd == SDCD_CMD_ROW_OPEN) chk("row", dec.row, e.row);
			if (e.cmd inside {SDCD_CMD_READ, SDCD_CMD_WRITE}) chk("col", 13'({dec.auto_pre, dec.col}), 13'({e.auto_pre, e.col}));
			if (e.cmd == SDCD_CMD_PRECHARGE) chk("all", 13'(dec.all_banks), 13'(e.all_banks));
		end
		if (cyc > 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		chk("ds", 13'(ds), 13'h1);
		chk("cl", 13'(cl), 13'h2);
		r = 13'($random(seed));
		cmd(4'b0011, 1'b1, 2'h1, r, SDCD_CMD_ROW_OPEN);
		cmd(4'b0101, 1'b1, 2'h1, r | 13'h0400, SDCD_CMD_READ);
		cmd(4'b0011, 1'b1, 2'h2, ~r, SDCD_CMD_ROW_OPEN);
		cmd(4'b0100, 1'b1, 2'h2, r & 13'h1bff, SDCD_CMD_WRITE);
		cmd(4'b0110, 1'b1, 2'h2, r, SDCD_CMD_BURST_STOP);
		req_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("banks", 13'(bank_open), 13'h4);
		cmd(4'b0010, 1'b1, 2'h2, 13'h0000, SDCD_CMD_PRECHARGE);
		cmd(4'b0011, 1'b1, 2'h0, r, SDCD_CMD_ROW_OPEN);
		cmd(4'b0010, 1'b1, 2'h3, 13'h0400, SDCD_CMD_PRECHARGE);
		cmd(4'b0001, 1'b1, 2'h0, r, SDCD_CMD_REFRESH);
		cmd(4'b0000, 1'b1, 2'h2, 13'h0000, SDCD_CMD_MODE_LOAD);
		cmd(4'b0000, 1'b1, 2'h0, 13'h0030, SDCD_CMD_MODE_LOAD);
		cmd(4'b0111, 1'b1, 2'h1, r, SDCD_CMD_NOP);
		cmd(4'b0001, 1'b0, 2'h0, r, SDCD_CMD_SELF_REFRESH);
		cmd(4'b0110, 1'b0, 2'h0, r, SDCD_CMD_DEEP_PD);
		req_valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("ds", 13'(ds), 13'h0);
		chk("cl", 13'(cl), 13'h3);
		chk("banks", 13'(bank_open), 13'h0);
		chk("err", 13'(timing_error), 13'h0);
		chk("mode", mw, 13'h0030);
		chk("ext", emw, 13'h0000);
		$display("TB: command walk done");
		burst_active <= 1'b1;
		cmd(4'b0000, 1'b1, 2'h0, 13'h0020, SDCD_CMD_MODE_LOAD);
		req_valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("err", 13'(timing_error), 13'h1);
		chk("queue", 13'(q.size()), 13'h0);
		$display("TB: fault test done");
		summarize();
	end
endmodule : sdcd_top_tb
bind sdcd_top sdcd_top_sva chk_u (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .read_active(read_active), .dec(dec),
	.cmd_valid(cmd_valid), .read_out_enable(read_out_enable), .drive_strength(drive_strength),
	.timing_error(timing_error), .deep_power_down(deep_power_down), .self_refresh(self_refresh),
	.write_mask(write_mask), .refresh_row(refresh_row), .refresh_bank(refresh_bank));
`default_nettype wire

// *** hw/sdcd_delay.sv ***
// Short shift line delaying a one-bit level by a fixed count of clocks.
`timescale 1ns/1ps
`default_nettype none
module sdcd_delay #(
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	logic [DEPTH-1:0] pipe_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pipe_reg <= '0;
		end else begin
			pipe_reg <= {pipe_reg[DEPTH-2:0], din};
		end
	end

	assign dout = pipe_reg[DEPTH-1];
endmodule : sdcd_delay
`default_nettype wire

// *** hw/sdcd_pkg.sv ***
// Types shared by the command decoder files.
`default_nettype none
package sdcd_pkg;
	`include "sdcd_regs.svh"

	typedef enum logic [3:0] {
		SDCD_CMD_NOP,
		SDCD_CMD_ROW_OPEN,
		SDCD_CMD_READ,
		SDCD_CMD_WRITE,
		SDCD_CMD_BURST_STOP,
		SDCD_CMD_DEEP_PD,
		SDCD_CMD_PRECHARGE,
		SDCD_CMD_REFRESH,
		SDCD_CMD_SELF_REFRESH,
		SDCD_CMD_MODE_LOAD,
		SDCD_CMD_MODE_RSVD
	} sdcd_cmd_t;

	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic dqm;
		logic [`SDCD_BANK_W-1:0] ba;
		logic [`SDCD_ROW_W-1:0] addr;
	} sdcd_pins_t;

	typedef struct packed {
		sdcd_cmd_t cmd;
		logic [`SDCD_BANK_W-1:0] bank;
		logic [`SDCD_ROW_W-1:0] row;
		logic [`SDCD_COL_W-1:0] col;
		logic auto_pre;
		logic all_banks;
	} sdcd_dec_t;
endpackage : sdcd_pkg
`default_nettype wire

// *** hw/sdcd_regs.svh ***
// Constants of the command decoder: pin encodings, field positions, mode defaults and timing.
`ifndef SDCD_REGS_SVH
`define SDCD_REGS_SVH

`define SDCD_ROW_W 13
`define SDCD_COL_W 9
`define SDCD_BANK_W 2
`define SDCD_NBANK 4
`define SDCD_AP_BIT 10
`define SDCD_DS_LSB 5
`define SDCD_DS_MSB 6
`define SDCD_CL_LSB 4
`define SDCD_CL_MSB 6
`define SDCD_MODE_MAIN 2'h0
`define SDCD_MODE_EXT 2'h2
`define SDCD_DS_FULL 2'h0
`define SDCD_DS_HALF 2'h1
`define SDCD_EXT_RESET 13'h0020
`define SDCD_MODE_RESET 13'h0020
`define SDCD_CL2 3'h2
`define SDCD_CL3 3'h3
`define SDCD_MASK_LAT 2
`define SDCD_MODE_LOAD_SPACING_CK 2
`define SDCD_CLK_PERIOD_NS 50
`define SDCD_OPEN_TO_ACCESS_NS 19
`define SDCD_SAME_BANK_OPEN_NS 67
`define SDCD_CROSS_BANK_OPEN_NS 15
`define SDCD_CYC(ns) (((ns) + `SDCD_CLK_PERIOD_NS - 1) / `SDCD_CLK_PERIOD_NS)

`endif

// *** hw/sdcd_top.sv ***
// Command decoder of a low-power synchronous DRAM, seen from inside the memory.
// Functional notes
// - Deselect or NOP starts nothing new.
// - Row open: bank and row A0-A12.
// - Read: bank and column A0-A8.
// - Write: bank and column, starts burst.
// - A10 high gives one-shot auto precharge.
// - Burst stop or deep power-down by CKE.
// - Precharge one bank, or all if A10.
// - Auto refresh or self refresh by CKE.
// - Refresh uses internal counter, ignores addresses.
// - Mode load: BA selects main or extended.
// - Mask blocks writes, tristates reads two later.
// - All inputs sampled on rising clock, except read_active, which gates read_out_enable directly.
// - Drive strength from extended bits A5-A6.
// - Read latency two or three clocks.
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_regs.svh"
module sdcd_top
	import sdcd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire sdcd_pkg::sdcd_pins_t pins,
	input wire logic burst_active,
	input wire logic read_active,
	output var sdcd_pkg::sdcd_dec_t dec,
	output logic cmd_valid,
	output logic [`SDCD_NBANK-1:0] bank_open,
	output logic [`SDCD_ROW_W-1:0] refresh_row,
	output logic [`SDCD_BANK_W-1:0] refresh_bank,
	output logic deep_power_down,
	output logic self_refresh,
	output logic write_mask,
	output logic read_out_enable,
	output logic [1:0] drive_strength,
	output logic [2:0] read_latency,
	output logic [`SDCD_ROW_W-1:0] mode_word,
	output logic [`SDCD_ROW_W-1:0] ext_mode_word,
	output logic timing_error
);
	import sdcd_pkg::*;

	localparam int OPEN_TO_ACCESS_CK = `SDCD_CYC(`SDCD_OPEN_TO_ACCESS_NS);
	localparam int SAME_BANK_OPEN_CK = `SDCD_CYC(`SDCD_SAME_BANK_OPEN_NS);
	localparam int CROSS_BANK_OPEN_CK = `SDCD_CYC(`SDCD_CROSS_BANK_OPEN_NS);
	localparam int TW = 4;

	// ****************************************************************
	// Input capture and decode
	// ****************************************************************
	sdcd_pins_t pins_reg;
	sdcd_dec_t dec_reg;
	sdcd_dec_t dec_next;
	logic cmd_valid_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pins_reg <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, dqm: 1'b1, default: '0};
		end else begin
			pins_reg <= pins;
		end
	end

	wire [3:0] code = {pins_reg.cs_n, pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n};
	wire ck_hi = pins_reg.cke;
	wire [`SDCD_BANK_W-1:0] ba_in = pins_reg.ba;
	wire a10 = pins_reg.addr[`SDCD_AP_BIT];

	always_comb begin
		dec_next = '0;
		dec_next.cmd = SDCD_CMD_NOP;
		dec_next.bank = ba_in;
		unique casez (code)
			4'b1???, 4'b0111: dec_next.cmd = SDCD_CMD_NOP;
			4'b0011: begin
				dec_next.cmd = SDCD_CMD_ROW_OPEN;
				dec_next.row = pins_reg.addr;
			end
			4'b0101: begin
				dec_next.cmd = SDCD_CMD_READ;
				dec_next.col = pins_reg.addr[`SDCD_COL_W-1:0];
				dec_next.auto_pre = a10;
			end
			4'b0100: begin
				dec_next.cmd = SDCD_CMD_WRITE;
				dec_next.col = pins_reg.addr[`SDCD_COL_W-1:0];
				dec_next.auto_pre = a10;
			end
			4'b0110: dec_next.cmd = ck_hi ? SDCD_CMD_BURST_STOP : SDCD_CMD_DEEP_PD;
			4'b0010: begin
				dec_next.cmd = SDCD_CMD_PRECHARGE;
				dec_next.all_banks = a10;
				dec_next.bank = a10 ? '0 : ba_in;
			end
			4'b0001: begin
				dec_next.cmd = ck_hi ? SDCD_CMD_REFRESH : SDCD_CMD_SELF_REFRESH;
				dec_next.bank = refresh_bank;
				dec_next.row = refresh_row;
			end
			4'b0000: begin
				dec_next.row = pins_reg.addr;
				dec_next.cmd = (ba_in == `SDCD_MODE_MAIN || ba_in == `SDCD_MODE_EXT)
					? SDCD_CMD_MODE_LOAD : SDCD_CMD_MODE_RSVD;
			end
		endcase
	end

	wire is_open = dec_next.cmd == SDCD_CMD_ROW_OPEN;
	wire is_access = dec_next.cmd == SDCD_CMD_READ || dec_next.cmd == SDCD_CMD_WRITE;
	wire is_pre = dec_next.cmd == SDCD_CMD_PRECHARGE;
	wire is_ref = dec_next.cmd == SDCD_CMD_REFRESH || dec_next.cmd == SDCD_CMD_SELF_REFRESH;
	wire is_mode = dec_next.cmd == SDCD_CMD_MODE_LOAD;
	wire is_exec = dec_next.cmd != SDCD_CMD_NOP;

	// ****************************************************************
	// Bank state and spacing timers
	// ****************************************************************
	logic [`SDCD_NBANK-1:0] open_reg;
	logic [`SDCD_NBANK-1:0] open_next;
	logic [TW-1:0] acc_tmr_reg [`SDCD_NBANK];
	logic [TW-1:0] rc_tmr_reg [`SDCD_NBANK];
	logic [TW-1:0] rrd_tmr_reg;
	logic [TW-1:0] mrd_tmr_reg;
	logic err_reg;
	logic err_next;
	logic bst_ap_reg;

	wire [`SDCD_NBANK-1:0] sel = `SDCD_NBANK'(1) << dec_next.bank;

	// Precharge clears the bank, an auto-precharged access clears it too.
	assign open_next = is_open ? (open_reg | sel)
		: is_pre ? (dec_next.all_banks ? '0 : (open_reg & ~sel))
		: (is_access && dec_next.auto_pre) ? (open_reg & ~sel)
		: open_reg;

	// Protocol breaches from the controller are flagged, not blocked.
	assign err_next = (is_exec && mrd_tmr_reg != '0)
		|| (is_mode && (open_reg != '0 || burst_active))
		|| (is_access && !open_reg[dec_next.bank])
		|| (is_access && acc_tmr_reg[dec_next.bank] != '0)
		|| (is_open && open_reg[dec_next.bank])
		|| (is_open && rc_tmr_reg[dec_next.bank] != '0)
		|| (is_open && rrd_tmr_reg != '0)
		|| (dec_next.cmd == SDCD_CMD_BURST_STOP && bst_ap_reg)
		|| dec_next.cmd == SDCD_CMD_MODE_RSVD;

	genvar b;
	generate
		for (b = 0; b < `SDCD_NBANK; b++) begin : g_bank
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					acc_tmr_reg[b] <= '0;
					rc_tmr_reg[b] <= '0;
				end else if (is_open && sel[b]) begin
					acc_tmr_reg[b] <= TW'(OPEN_TO_ACCESS_CK - 1);
					rc_tmr_reg[b] <= TW'(SAME_BANK_OPEN_CK - 1);
				end else begin
					acc_tmr_reg[b] <= (acc_tmr_reg[b] != '0) ? acc_tmr_reg[b] - 1'b1 : '0;
					rc_tmr_reg[b] <= (rc_tmr_reg[b] != '0) ? rc_tmr_reg[b] - 1'b1 : '0;
				end
			end
		end
	endgenerate

	wire [TW-1:0] rrd_next = is_open ? TW'(CROSS_BANK_OPEN_CK - 1)
		: (rrd_tmr_reg != '0) ? rrd_tmr_reg - 1'b1 : '0;
	wire [TW-1:0] mrd_next = is_mode ? TW'(`SDCD_MODE_LOAD_SPACING_CK - 1)
		: (mrd_tmr_reg != '0) ? mrd_tmr_reg - 1'b1 : '0;
	wire bst_ap_next = is_access ? dec_next.auto_pre : bst_ap_reg;

	// ****************************************************************
	// Refresh counter, power states and mode words
	// ****************************************************************
	logic [`SDCD_ROW_W+`SDCD_BANK_W-1:0] rfc_reg;
	logic dpd_reg;
	logic sref_reg;
	logic [`SDCD_ROW_W-1:0] mode_reg;
	logic [`SDCD_ROW_W-1:0] ext_reg;

	wire [`SDCD_ROW_W+`SDCD_BANK_W-1:0] rfc_next = is_ref ? rfc_reg + 1'b1 : rfc_reg;
	wire dpd_next = (dec_next.cmd == SDCD_CMD_DEEP_PD) ? 1'b1 : (ck_hi ? 1'b0 : dpd_reg);
	wire sref_next = (dec_next.cmd == SDCD_CMD_SELF_REFRESH) ? 1'b1 : (ck_hi ? 1'b0 : sref_reg);
	wire load_main = is_mode && ba_in == `SDCD_MODE_MAIN;
	wire load_ext = is_mode && ba_in == `SDCD_MODE_EXT;
	wire [2:0] cl_field = mode_reg[`SDCD_CL_MSB:`SDCD_CL_LSB];

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dec_reg <= '0;
			cmd_valid_reg <= 1'b0;
			open_reg <= '0;
			rrd_tmr_reg <= '0;
			mrd_tmr_reg <= '0;
			err_reg <= 1'b0;
			bst_ap_reg <= 1'b0;
			rfc_reg <= '0;
			dpd_reg <= 1'b0;
			sref_reg <= 1'b0;
			mode_reg <= `SDCD_MODE_RESET;
			ext_reg <= `SDCD_EXT_RESET;
		end else begin
			dec_reg <= dec_next;
			cmd_valid_reg <= is_exec;
			open_reg <= open_next;
			rrd_tmr_reg <= rrd_next;
			mrd_tmr_reg <= mrd_next;
			err_reg <= err_reg | err_next;
			bst_ap_reg <= bst_ap_next;
			rfc_reg <= rfc_next;
			dpd_reg <= dpd_next;
			sref_reg <= sref_next;
			mode_reg <= load_main ? pins_reg.addr : mode_reg;
			ext_reg <= load_ext ? pins_reg.addr : ext_reg;
		end
	end

	// ****************************************************************
	// Data mask
	// ****************************************************************
	logic mask_late;

	sdcd_delay #(
		.DEPTH(`SDCD_MASK_LAT)
	) u_mask_delay (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.din(pins_reg.dqm),
		.dout(mask_late)
	);

	assign write_mask = pins_reg.dqm;
	assign read_out_enable = read_active && !mask_late;

	assign dec = dec_reg;
	assign cmd_valid = cmd_valid_reg;
	assign bank_open = open_reg;
	assign refresh_row = rfc_reg[`SDCD_ROW_W-1:0];
	assign refresh_bank = rfc_reg[`SDCD_ROW_W+`SDCD_BANK_W-1:`SDCD_ROW_W];
	assign deep_power_down = dpd_reg;
	assign self_refresh = sref_reg;
	assign drive_strength = ext_reg[`SDCD_DS_MSB:`SDCD_DS_LSB];
	assign read_latency = (cl_field == `SDCD_CL3) ? `SDCD_CL3 : `SDCD_CL2;
	assign mode_word = mode_reg;
	assign ext_mode_word = ext_reg;
	assign timing_error = err_reg;
endmodule : sdcd_top
`default_nettype wire
